//--- scan_and_boundary_test_port_test.sv
// Self-checking bench for the scan chains and the test access port.
module scan_and_boundary_test_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int L = 8;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic mode_n = 1'b1;
  logic scan_en = 1'b0;
  logic [7:0] req1 = 8'hff, req2 = 8'hff, gf1 = 8'hff, gf2 = 8'hff, g1, g2, e1, e2;
  logic [scan_tap_pkg::NUM_CHAINS*L-1:0] cap = '0;
  logic [L-1:0] ch [10];
  logic active, tck, trst_n, tms, tdi, tdo, oe, d, o, b;
  logic e_act = 1'b0, skip = 1'b1, chk = 1'b0, prev = 1'b0;
  int error_cnt = 0;
  int tests_run = 0;
  always #5 clk = ~clk;
  scan_test_port #(.CHAIN_LEN(L)) dut (.CLK_I(clk), .RESETN_I(rst_n),
    .SCAN_TEST_MODE_N_I(mode_n), .SCAN_EN_I(scan_en), .SEC1_BUS_REQUEST_PINS_I(req1),
    .SEC2_BUS_REQUEST_PINS_I(req2), .SEC1_GNT_FUNC_I(gf1), .SEC2_GNT_FUNC_I(gf2),
    .SEC1_BUS_GRANT_PINS_O(g1), .SEC2_BUS_GRANT_PINS_O(g2), .FUNC_CAPTURE_I(cap),
    .SCAN_ACTIVE_O(active), .TCK_I(tck), .TRST_N_I(trst_n), .TMS_I(tms), .TDI_I(tdi),
    .TDO_O(tdo), .TDO_OE_O(oe));
  tap_tester tester (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n),
    .tdo_i(tdo), .oe_i(oe));
  // Reference model of the chains and the grant register; mode changes are not judged.
  always @(posedge clk) begin
    skip = !rst_n || (!mode_n != prev);
    prev = !mode_n;
    e1 = rst_n ? gf1 : 8'hff;
    e2 = rst_n ? gf2 : 8'hff;
    e_act = rst_n && !mode_n;
    for (int g = 0; g < 10; g++) begin
      if (!rst_n) ch[g] = '0;
      else if (!mode_n) begin
        if (g < 5) e1[2+g] = ch[g][L-1];
        else e2[g-3] = ch[g][L-1];
        ch[g] = scan_en ? cap[g*L +: L] : {ch[g][L-2:0], g < 5 ? req1[2+g] : req2[g-3]};
      end
    end
  end
  always @(negedge clk) begin
    if (chk && !skip) begin
      check_grants("grant pins", {e2, e1}, {g2, g1});
      check_bit("scan_active", e_act, active);
    end
  end
  task automatic check_grants(input string n, input logic [15:0] e, input logic [15:0] s);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic check_bit(input string n, input logic e, input logic s);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %b seen %b", n, e, s);
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d, errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
      req1 = 8'($urandom);
      req2 = 8'($urandom);
      gf1 = 8'($urandom);
      gf2 = 8'($urandom);
      for (int i = 0; i < 10; i++) cap[i*L +: L] = L'($urandom);
    end
  endtask
  task automatic set_en(input logic v);
    @(posedge clk);
    #1 scan_en = v;
  endtask
  task automatic tstep(input logic m, input logic i, input logic et, input logic eo, input bit ct);
    tester.step(m, i, d, o);
    check_bit("tdo_oe", eo, o);
    if (ct) check_bit("tdo", et, d);
  endtask
  task automatic walk(input int n, input logic [7:0] m, input logic [7:0] eo);
    for (int k = 0; k < n; k++) tstep(m[k], 1'b1, 1'b0, eo[k], 1'b0);
  endtask
  initial begin
    #100000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    void'($urandom(20));
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    chk = 1'b1;
    check_grants("reset grants", 16'hffff, {g2, g1});
    // Scan enable stays low in normal operation.
    cycles(20);
    mode_n = 1'b0;
    cycles(3 * L);
    repeat (3) begin
      set_en(1'b1);
      set_en(1'b0);
      cycles(L + 2);
    end
    mode_n = 1'b1;
    cycles(10);
    mode_n = 1'b0;
    set_en(1'b1);
    fork
      cycles(220);
      begin
        tester.reset_port(d, o);
        check_bit("tdo_oe", 1'b0, o);
        walk(4, 8'b0110, 8'h00);
        tstep(1'b0, 1'b1, 1'b1, 1'b1, 1);
        tstep(1'b0, 1'b1, 1'b0, 1'b1, 1);
        walk(7, 8'b0101100, 8'b0000011);
        tstep(1'b0, 1'b1, 1'b0, 1'b1, 1);
        repeat (6) begin
          b = 1'($urandom);
          tstep(1'b0, b, b, 1'b1, 1);
        end
        walk(5, 8'b11111, 8'h00);
        walk(4, 8'b0010, 8'b1000);
        set_en(1'b0);
        tstep(1'b0, 1'b1, 1'b0, 1'b0, 1);
        set_en(1'b1);
        tstep(1'b0, 1'b1, 1'b1, 1'b1, 1);
        tester.reset_port(d, o);
        check_bit("tdo_oe", 1'b0, o);
      end
    join
    end_of_test();
  end
endmodule

//--- scan_tap_pkg.sv
// Package with constants and carrier types for the scan and boundary test port.
package scan_tap_pkg;
  localparam int unsigned NUM_CHAINS = 10;
  localparam int unsigned IR_WIDTH = 4;
  localparam logic [3:0] IR_RESET = 4'h1;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [3:0] IR_SAMPLE = 4'h2;
  localparam logic [1:0] IR_CAPTURE = 2'h1;
  localparam int unsigned NUM_REQ_PINS = 8;
  localparam int unsigned NUM_GNT_PINS = 8;
  localparam int unsigned IN_LSB = 2;
  localparam int unsigned OUT_LSB = 2;

  typedef enum logic [15:0] {
    TEST_RESET = 16'h0001,
    RUN_IDLE = 16'h0002,
    SEL_DR = 16'h0004,
    CAP_DR = 16'h0008,
    SHIFT_DR = 16'h0010,
    EXIT1_DR = 16'h0020,
    PAUSE_DR = 16'h0040,
    EXIT2_DR = 16'h0080,
    UPD_DR = 16'h0100,
    SEL_IR = 16'h0200,
    CAP_IR = 16'h0400,
    SHIFT_IR = 16'h0800,
    EXIT1_IR = 16'h1000,
    PAUSE_IR = 16'h2000,
    EXIT2_IR = 16'h4000,
    UPD_IR = 16'h8000
  } tap_state_t;

  typedef struct packed {
    logic tms;
    logic tdi;
    logic trst_n;
  } tap_in_t;

  typedef struct packed {
    logic active;
    logic shift;
    logic capture;
  } scan_ctl_t;
endpackage

//--- scan_test_port.sv
// Full-scan controls and boundary-scan test access port of the bridge.
// Overview of operation
// - Active-low test mode enables the ten scan chains; high means normal operation.
// - Scan chains are clocked by the primary bus clock only.
// - Scan enable low in test mode shifts the chains serially.
// - Scan enable high in test mode captures functional values in parallel.
// - The test clock times all boundary-scan state and data movement.
// - Mode select steers the access port controller between its states.
// - With scan enable high, data leaves serially on test data output.
// - With scan enable high, test data input shifts into the access port.
// - Active-low test reset forces the controller to its initial state.
module scan_test_port #(
  parameter int unsigned CHAIN_LEN = 16
) (
  // Primary clock and reset
  input wire logic CLK_I,
  input wire logic RESETN_I,
  // Full-scan controls
  input wire logic SCAN_TEST_MODE_N_I,
  input wire logic SCAN_EN_I,
  // Borrowed arbitration pins
  input wire logic [scan_tap_pkg::NUM_REQ_PINS-1:0] SEC1_BUS_REQUEST_PINS_I,
  input wire logic [scan_tap_pkg::NUM_REQ_PINS-1:0] SEC2_BUS_REQUEST_PINS_I,
  input wire logic [scan_tap_pkg::NUM_GNT_PINS-1:0] SEC1_GNT_FUNC_I,
  input wire logic [scan_tap_pkg::NUM_GNT_PINS-1:0] SEC2_GNT_FUNC_I,
  output logic [scan_tap_pkg::NUM_GNT_PINS-1:0] SEC1_BUS_GRANT_PINS_O,
  output logic [scan_tap_pkg::NUM_GNT_PINS-1:0] SEC2_BUS_GRANT_PINS_O,
  // Functional values captured into the chains
  input wire logic [scan_tap_pkg::NUM_CHAINS*CHAIN_LEN-1:0] FUNC_CAPTURE_I,
  output logic SCAN_ACTIVE_O,
  // Test access port
  input wire logic TCK_I,
  input wire logic TRST_N_I,
  input wire logic TMS_I,
  input wire logic TDI_I,
  output logic TDO_O,
  output logic TDO_OE_O
);
  localparam int unsigned NC = scan_tap_pkg::NUM_CHAINS;
  localparam int unsigned HALF = NC / 2;

  // Elaboration checks on the chain geometry and the borrowed pin groups.
  if (CHAIN_LEN < 2) begin : g_bad_len
    $error("CHAIN_LEN must be at least 2");
  end
  if (NC % 2 != 0) begin : g_bad_count
    $error("The chain count must be even to split across both pin groups");
  end
  if (scan_tap_pkg::IN_LSB + HALF > scan_tap_pkg::NUM_REQ_PINS) begin : g_bad_in
    $error("Chain inputs do not fit on the request pins");
  end
  if (scan_tap_pkg::OUT_LSB + HALF > scan_tap_pkg::NUM_GNT_PINS) begin : g_bad_out
    $error("Chain outputs do not fit on the grant pins");
  end

  scan_tap_pkg::scan_ctl_t ctl;
  logic [NC-1:0] chain_in;
  logic [NC-1:0] chain_out;
  logic [CHAIN_LEN-1:0] chain_q [NC];
  logic [HALF-1:0] s1_out_sel;
  logic [HALF-1:0] s2_out_sel;

  // Test mode is the inverted pin.
  assign ctl.active = !SCAN_TEST_MODE_N_I;
  assign ctl.shift = ctl.active && !SCAN_EN_I;
  assign ctl.capture = ctl.active && SCAN_EN_I;

  // Chain inputs come from request pins.
  assign chain_in = {SEC2_BUS_REQUEST_PINS_I[scan_tap_pkg::IN_LSB +: HALF],
                     SEC1_BUS_REQUEST_PINS_I[scan_tap_pkg::IN_LSB +: HALF]};

  genvar g;
  for (g = 0; g < NC; g++) begin : g_chain
    assign chain_out[g] = chain_q[g][CHAIN_LEN-1];
    // Chains run on the primary clock.
    always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
        chain_q[g] <= '0;
      end else if (ctl.shift) begin
        chain_q[g] <= {chain_q[g][CHAIN_LEN-2:0], chain_in[g]};
      end else if (ctl.capture) begin
        chain_q[g] <= FUNC_CAPTURE_I[g*CHAIN_LEN +: CHAIN_LEN];
      end
    end
  end

  // Chain outputs replace grant bits in test mode.
  assign s1_out_sel = chain_out[HALF-1:0];
  assign s2_out_sel = chain_out[NC-1:HALF];

  logic [scan_tap_pkg::NUM_GNT_PINS-1:0] sec1_bus_grant_pins_d;
  logic [scan_tap_pkg::NUM_GNT_PINS-1:0] sec2_bus_grant_pins_d;
  always_comb begin
    sec1_bus_grant_pins_d = SEC1_GNT_FUNC_I;
    sec2_bus_grant_pins_d = SEC2_GNT_FUNC_I;
    if (ctl.active) begin
      sec1_bus_grant_pins_d[scan_tap_pkg::OUT_LSB +: HALF] = s1_out_sel;
      sec2_bus_grant_pins_d[scan_tap_pkg::OUT_LSB +: HALF] = s2_out_sel;
    end
  end

  // Grant pins are deasserted (high) out of reset.
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      SEC1_BUS_GRANT_PINS_O <= '1;
      SEC2_BUS_GRANT_PINS_O <= '1;
      SCAN_ACTIVE_O <= 1'b0;
    end else begin
      SEC1_BUS_GRANT_PINS_O <= sec1_bus_grant_pins_d;
      SEC2_BUS_GRANT_PINS_O <= sec2_bus_grant_pins_d;
      SCAN_ACTIVE_O <= ctl.active;
    end
  end

  // Boundary-scan side, entirely on the test clock.
  scan_tap_pkg::tap_state_t tap_state;
  scan_tap_pkg::tap_in_t tin;
  assign tin = '{tms: TMS_I, tdi: TDI_I, trst_n: TRST_N_I};

  // Controller clocked by the test clock.
  tap_fsm u_fsm (
    .tck_i(TCK_I),
    .trst_n_i(tin.trst_n),
    .tms_i(tin.tms),
    .state_o(tap_state)
  );

  logic [scan_tap_pkg::IR_WIDTH-1:0] ir_sh_q;
  logic [scan_tap_pkg::IR_WIDTH-1:0] ir_q;
  logic bypass_q;
  logic in_shift_ir;
  logic in_shift_dr;
  logic tap_shift_ok;
  logic serial_bit;

  // Serial path runs only with scan enable high.
  assign tap_shift_ok = SCAN_EN_I;
  assign in_shift_ir = tap_state == scan_tap_pkg::SHIFT_IR;
  assign in_shift_dr = tap_state == scan_tap_pkg::SHIFT_DR;
  assign serial_bit = in_shift_ir ? ir_sh_q[0] : bypass_q;

  // Sample test data on rising test clock.
  always_ff @(posedge TCK_I) begin
    if (!tin.trst_n || tap_state == scan_tap_pkg::TEST_RESET) begin
      ir_sh_q <= '0;
      ir_q <= scan_tap_pkg::IR_RESET;
      bypass_q <= 1'b0;
    end else begin
      if (tap_state == scan_tap_pkg::CAP_IR) begin
        ir_sh_q <= {{(scan_tap_pkg::IR_WIDTH-2){1'b0}}, scan_tap_pkg::IR_CAPTURE};
      end else if (in_shift_ir && tap_shift_ok) begin
        ir_sh_q <= {tin.tdi, ir_sh_q[scan_tap_pkg::IR_WIDTH-1:1]};
      end
      if (tap_state == scan_tap_pkg::UPD_IR) begin
        ir_q <= ir_sh_q;
      end
      if (tap_state == scan_tap_pkg::CAP_DR) begin
        bypass_q <= 1'b0;
      end else if (in_shift_dr && tap_shift_ok) begin
        bypass_q <= tin.tdi;
      end
    end
  end

  // Output changes on falling test clock.
  always_ff @(negedge TCK_I) begin
    if (!tin.trst_n) begin
      TDO_O <= 1'b0;
      TDO_OE_O <= 1'b0;
    end else begin
      TDO_O <= serial_bit;
      TDO_OE_O <= (in_shift_ir || in_shift_dr) && tap_shift_ok;
    end
  end

  trst_init_a: assert property (@(posedge TCK_I) !TRST_N_I |=>
    tap_state == scan_tap_pkg::TEST_RESET) else $error("tap not reset");
  grant_scan_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    !SCAN_TEST_MODE_N_I |=> SEC1_BUS_GRANT_PINS_O[scan_tap_pkg::OUT_LSB] ==
    $past(chain_q[0][CHAIN_LEN-1])) else $error("grant not chain out");
  chain_shift_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    ctl.shift |=> chain_q[0][0] == $past(chain_in[0])) else $error("no shift");
  chain_cap_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    ctl.capture |=> chain_q[0] == $past(FUNC_CAPTURE_I[CHAIN_LEN-1:0]))
    else $error("no capture");
  normal_gnt_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    SCAN_TEST_MODE_N_I |=> SEC2_BUS_GRANT_PINS_O == $past(SEC2_GNT_FUNC_I))
    else $error("grant not functional");
  chain_hold_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    SCAN_TEST_MODE_N_I |=> $stable(chain_q[1])) else $error("chain moved");
  tms_reset_a: assert property (@(posedge TCK_I) disable iff (!TRST_N_I)
    TMS_I [*5] |=> tap_state == scan_tap_pkg::TEST_RESET) else $error("tms reset");
  bypass_a: assert property (@(posedge TCK_I) disable iff (!TRST_N_I)
    in_shift_dr && SCAN_EN_I |=> bypass_q == $past(TDI_I)) else $error("bypass");
  scan_active_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    !SCAN_TEST_MODE_N_I |=> SCAN_ACTIVE_O) else $error("scan active flag not set");
  last_shift_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    ctl.shift |=> chain_q[NC-1][0] == $past(chain_in[NC-1])) else $error("last chain no shift");
  last_capture_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    ctl.capture |=> chain_q[NC-1] == $past(FUNC_CAPTURE_I[(NC-1)*CHAIN_LEN +: CHAIN_LEN]))
    else $error("last chain no capture");
  grant_sec2_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    !SCAN_TEST_MODE_N_I |=> SEC2_BUS_GRANT_PINS_O[scan_tap_pkg::OUT_LSB + HALF - 1] ==
    $past(chain_q[NC-1][CHAIN_LEN-1])) else $error("second grant not chain out");
  ir_update_a: assert property (@(posedge TCK_I) disable iff (!TRST_N_I)
    tap_state == scan_tap_pkg::UPD_IR |=> ir_q == $past(ir_sh_q))
    else $error("instruction not updated");
  ir_reset_a: assert property (@(posedge TCK_I) disable iff (!TRST_N_I)
    tap_state == scan_tap_pkg::TEST_RESET |=> ir_q == scan_tap_pkg::IR_RESET)
    else $error("instruction not reset");
  shift_refused_a: assert property (@(posedge TCK_I) disable iff (!TRST_N_I)
    in_shift_dr && !SCAN_EN_I |=> $stable(bypass_q)) else $error("shift not refused");
endmodule

//--- tap_fsm.sv
// Sixteen-state test access port controller on the test clock.
module tap_fsm (
  // Test clock and reset
  input wire logic tck_i,
  input wire logic trst_n_i,
  // Mode select
  input wire logic tms_i,
  // Current state
  output scan_tap_pkg::tap_state_t state_o
);
  scan_tap_pkg::tap_state_t state_q;
  scan_tap_pkg::tap_state_t state_d;

  always_comb begin
    unique case (state_q)
      scan_tap_pkg::TEST_RESET: state_d = tms_i ? scan_tap_pkg::TEST_RESET : scan_tap_pkg::RUN_IDLE;
      scan_tap_pkg::RUN_IDLE: state_d = tms_i ? scan_tap_pkg::SEL_DR : scan_tap_pkg::RUN_IDLE;
      scan_tap_pkg::SEL_DR: state_d = tms_i ? scan_tap_pkg::SEL_IR : scan_tap_pkg::CAP_DR;
      scan_tap_pkg::CAP_DR: state_d = tms_i ? scan_tap_pkg::EXIT1_DR : scan_tap_pkg::SHIFT_DR;
      scan_tap_pkg::SHIFT_DR: state_d = tms_i ? scan_tap_pkg::EXIT1_DR : scan_tap_pkg::SHIFT_DR;
      scan_tap_pkg::EXIT1_DR: state_d = tms_i ? scan_tap_pkg::UPD_DR : scan_tap_pkg::PAUSE_DR;
      scan_tap_pkg::PAUSE_DR: state_d = tms_i ? scan_tap_pkg::EXIT2_DR : scan_tap_pkg::PAUSE_DR;
      scan_tap_pkg::EXIT2_DR: state_d = tms_i ? scan_tap_pkg::UPD_DR : scan_tap_pkg::SHIFT_DR;
      scan_tap_pkg::UPD_DR: state_d = tms_i ? scan_tap_pkg::SEL_DR : scan_tap_pkg::RUN_IDLE;
      scan_tap_pkg::SEL_IR: state_d = tms_i ? scan_tap_pkg::TEST_RESET : scan_tap_pkg::CAP_IR;
      scan_tap_pkg::CAP_IR: state_d = tms_i ? scan_tap_pkg::EXIT1_IR : scan_tap_pkg::SHIFT_IR;
      scan_tap_pkg::SHIFT_IR: state_d = tms_i ? scan_tap_pkg::EXIT1_IR : scan_tap_pkg::SHIFT_IR;
      scan_tap_pkg::EXIT1_IR: state_d = tms_i ? scan_tap_pkg::UPD_IR : scan_tap_pkg::PAUSE_IR;
      scan_tap_pkg::PAUSE_IR: state_d = tms_i ? scan_tap_pkg::EXIT2_IR : scan_tap_pkg::PAUSE_IR;
      scan_tap_pkg::EXIT2_IR: state_d = tms_i ? scan_tap_pkg::UPD_IR : scan_tap_pkg::SHIFT_IR;
      scan_tap_pkg::UPD_IR: state_d = tms_i ? scan_tap_pkg::SEL_DR : scan_tap_pkg::RUN_IDLE;
      default: state_d = scan_tap_pkg::TEST_RESET;
    endcase
  end

  always_ff @(posedge tck_i) begin
    if (!trst_n_i) begin
      state_q <= scan_tap_pkg::TEST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign state_o = state_q;
endmodule

//--- tap_tester.sv
// Tester model that drives the three test access port input lines and the port reset.
module tap_tester (
  // Port lines
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  output logic trst_n_o,
  // Answer from the port
  input wire logic tdo_i,
  input wire logic oe_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
    trst_n_o = 1'b1;
  end
  // Lines move with the clock low, then one clock pulse.
  task automatic step(input logic m, input logic i, output logic t, output logic e);
    tms_o = m;
    tdi_o = i;
    #10 tck_o = 1'b1;
    #20 tck_o = 1'b0;
    #5 t = tdo_i;
    e = oe_i;
    // The released data line floats to its pull-up level.
    tdi_o = 1'b1;
    #5;
  endtask
  // Port reset held low across one rising test clock.
  task automatic reset_port(output logic t, output logic e);
    trst_n_o = 1'b0;
    step(1'b1, 1'b1, t, e);
    trst_n_o = 1'b1;
  endtask
endmodule
